// ==== design/fcd_pkg.sv ====
package fcd_pkg;
  // bus geometry
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BUF_WORDS = 16;

  // unlock and command addresses
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2aa;
  localparam logic [ADDR_W-1:0] CFI_ADDR = 22'h000055;
  localparam logic [ADDR_W-1:0] DONT_CARE_ADDR = 22'h000000;

  // command data bytes
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_SECURE = 8'h88;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_COMMIT = 8'h29;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_CFI = 8'h98;

  // autoselect offsets
  localparam logic [7:0] AS_MAKER = 8'h00;
  localparam logic [7:0] AS_PART0 = 8'h01;
  localparam logic [7:0] AS_PROTECT = 8'h02;
  localparam logic [7:0] AS_SECLOCK = 8'h03;
  localparam logic [7:0] AS_PART1 = 8'h0e;
  localparam logic [7:0] AS_PART2 = 8'h0f;
  localparam int SECTOR_LSB = 15;

  // bus timing in cycles of the 40 MHz clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int WE_LOW_NS = 50;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_ACC_NS = 100;
  localparam int RD_ACC_CYC = (RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = 1;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] WE_LOW_CNT = CNT_W'(WE_LOW_CYC);
  localparam logic [CNT_W-1:0] RD_ACC_CNT = CNT_W'(RD_ACC_CYC);
  localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_CYC);

  // host command codes
  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_RESET      = 4'h1,
    OP_AUTOSEL    = 4'h2,
    OP_SEC_ENTER  = 4'h3,
    OP_SEC_EXIT   = 4'h4,
    OP_PROGRAM    = 4'h5,
    OP_BUF_PROG   = 4'h6,
    OP_ABORT_RST  = 4'h7,
    OP_BYP_ENTER  = 4'h8,
    OP_BYP_PROG   = 4'h9,
    OP_BYP_EXIT   = 4'ha,
    OP_CHIP_ERASE = 4'hb,
    OP_SECT_ERASE = 4'hc,
    OP_SUSPEND    = 4'hd,
    OP_RESUME     = 4'he,
    OP_CFI        = 4'hf
  } fcd_op_t;
endpackage

// ==== design/fcd_bus_cycle.sv ====
`timescale 1ns/1ps
// one flash bus cycle
module fcd_bus_cycle
  import fcd_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              start_i,
  input  wire logic              is_write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe_o,
  output logic                   ce_b_o,
  output logic                   we_b_o,
  output logic                   oe_b_o
);
  typedef enum logic [1:0] {
    BC_IDLE = 2'b00,
    BC_ACT  = 2'b01,
    BC_GAP  = 2'b10
  } fcd_bc_t;

  fcd_bc_t           st_reg, st_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic              wr_reg, wr_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] dq_reg, dq_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  logic              done_reg, done_next;

  // strobe timing; address steady over the pulse
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    dq_next = dq_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    case (st_reg)
      BC_IDLE: begin
        if (start_i) begin
          st_next = BC_ACT;
          wr_next = is_write_i;
          addr_next = addr_i;
          dq_next = wdata_i;
          cnt_next = is_write_i ? WE_LOW_CNT : RD_ACC_CNT;
        end
      end
      BC_ACT: begin
        if (cnt_reg == CNT_W'(1)) begin
          st_next = BC_GAP;
          cnt_next = GAP_CNT;
          if (!wr_reg) begin
            rd_next = dq_i;
          end
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      BC_GAP: begin
        // one idle cycle gives a clean rising edge
        st_next = BC_IDLE;
        done_next = 1'b1;
      end
      default: st_next = BC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= BC_IDLE;
      cnt_reg <= '0;
      wr_reg <= 1'b0;
      addr_reg <= '0;
      dq_reg <= '0;
      rd_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      dq_reg <= dq_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
    end
  end

  // on writes ce and we move together, so latch edges coincide
  assign busy_o = (st_reg != BC_IDLE);
  assign done_o = done_reg;
  assign rdata_o = rd_reg;
  assign addr_o = addr_reg;
  assign dq_o = dq_reg;
  assign dq_oe_o = (st_reg != BC_IDLE) && wr_reg;
  assign ce_b_o = (st_reg != BC_ACT);
  assign we_b_o = !((st_reg == BC_ACT) && wr_reg);
  assign oe_b_o = !((st_reg == BC_ACT) && !wr_reg);
endmodule

// ==== design/fcd_host.sv ====
`timescale 1ns/1ps
// Overview of operation
// - unlock is AA at 555 then 55 at 2AA; high bits don't care.
// - F0 anywhere returns to read mode.
// - autoselect is unlock plus 90 at 555, then read offset 00, 01, 02 or 03.
// - part identity is three reads at offsets 01, 0e and 0f.
// - buffer load is unlock, 25 at sector, then count minus one.
// - all buffer addresses stay in the first address's buffer page; the host adds the word index to the start address with no page check.
// - 29 at sector commits buffer; at most 21 cycles.
// - after buffer abort, unlock plus F0 at 555 clears the abort.
// - bypass is unlock plus 20; then two-cycle A0 programs.
// - bypass left by 90 then 00 at any address.
// - secured region in by unlock plus 88; out by unlock, 90, 00.
// - chip erase is unlock, 80, unlock, 10; others ignored meanwhile.
// - sector erase ends 30 at sector; one sector per command.
module fcd_host
  import fcd_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              cmd_valid_i,
  input  wire fcd_op_t           cmd_op_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_data_i,
  input  wire logic [3:0]        cmd_count_i,
  input  wire logic [DATA_W-1:0] buf_data_i [BUF_WORDS],
  output logic                   cmd_ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [DATA_W-1:0]      id_word1_o,
  output logic [DATA_W-1:0]      id_word2_o,
  output logic                   bypass_o,
  output logic                   suspended_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output logic                   flash_ce_b_o,
  output logic                   flash_we_b_o,
  output logic                   flash_oe_b_o
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_ISSUE = 2'b01,
    HS_WAIT = 2'b10
  } fcd_hs_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcd_step_t;

  fcd_hs_t           st_reg, st_next;
  fcd_op_t           op_reg, op_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic [3:0]        wc_reg, wc_next;
  logic [4:0]        idx_reg, idx_next;
  logic [4:0]        last_reg, last_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  logic [DATA_W-1:0] id1_reg, id1_next;
  logic [DATA_W-1:0] id2_reg, id2_next;
  logic              byp_reg, byp_next;
  logic              susp_reg, susp_next;
  logic              erasing_reg, erasing_next;
  logic              done_reg, done_next;
  fcd_step_t         step;
  logic              bc_start;
  logic              bc_busy;
  logic              bc_done;
  logic [DATA_W-1:0] bc_rdata;

  // unlock address, upper bits zero
  function automatic logic [ADDR_W-1:0] ulk(input logic [10:0] a);
    ulk = {{(ADDR_W-11){1'b0}}, a};
  endfunction

  // command byte in low lane
  function automatic logic [DATA_W-1:0] cb(input logic [7:0] d);
    cb = {8'h00, d};
  endfunction

  // sector base address
  function automatic logic [ADDR_W-1:0] sect(input logic [ADDR_W-1:0] a);
    sect = {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
  endfunction

  // bus cycles of a command minus one
  function automatic logic [4:0] seq_last(input fcd_op_t op, input logic [3:0] wc);
    case (op)
      OP_READ, OP_RESET, OP_SUSPEND, OP_RESUME, OP_CFI: seq_last = 5'd0;
      OP_SEC_ENTER, OP_BYP_ENTER, OP_ABORT_RST: seq_last = 5'd2;
      OP_AUTOSEL, OP_SEC_EXIT, OP_PROGRAM: seq_last = 5'd3;
      OP_BYP_PROG, OP_BYP_EXIT: seq_last = 5'd1;
      OP_CHIP_ERASE, OP_SECT_ERASE: seq_last = 5'd5;
      // unlock x2, 25, count, wc+1 words, commit: at most 21 cycles
      OP_BUF_PROG: seq_last = 5'd5 + {1'b0, wc};
      default: seq_last = 5'd0;
    endcase
  endfunction

  // step table: bus cycle at index idx_reg
  always_comb begin
    step.wr = 1'b1;
    step.addr = DONT_CARE_ADDR;
    step.data = '0;
    case (op_reg)
      OP_READ: begin
        step.wr = 1'b0;
        step.addr = addr_reg;
      end
      OP_RESET, OP_SUSPEND, OP_RESUME, OP_CFI: begin
        step.addr = (op_reg == OP_CFI) ? CFI_ADDR : addr_reg;
        step.data = cb(op_reg == OP_RESET ? CMD_RESET :
                       op_reg == OP_SUSPEND ? CMD_SUSPEND :
                       op_reg == OP_RESUME ? CMD_RESUME : CMD_CFI);
      end
      OP_BYP_PROG, OP_BYP_EXIT: begin
        // two-cycle forms, bypass mode only
        step.addr = (idx_reg == 5'd0) ? DONT_CARE_ADDR : addr_reg;
        if (op_reg == OP_BYP_PROG) begin
          step.data = (idx_reg == 5'd0) ? cb(CMD_PROGRAM) : data_reg;
        end else begin
          step.data = cb(idx_reg == 5'd0 ? CMD_AUTOSEL : CMD_EXIT2);
          step.addr = DONT_CARE_ADDR;
        end
      end
      default: begin
        // unlocked sequences open with the unlock pair
        if (idx_reg == 5'd0 || (idx_reg == 5'd3 && (op_reg == OP_CHIP_ERASE ||
            op_reg == OP_SECT_ERASE))) begin
          step.addr = ulk(UNLOCK_ADDR1);
          step.data = cb(CMD_UNLOCK1);
        end else if (idx_reg == 5'd1 || (idx_reg == 5'd4 && (op_reg == OP_CHIP_ERASE ||
                     op_reg == OP_SECT_ERASE))) begin
          step.addr = ulk(UNLOCK_ADDR2);
          step.data = cb(CMD_UNLOCK2);
        end else if (idx_reg == 5'd2) begin
          step.addr = ulk(UNLOCK_ADDR1);
          case (op_reg)
            OP_AUTOSEL, OP_SEC_EXIT: step.data = cb(CMD_AUTOSEL);
            OP_SEC_ENTER: step.data = cb(CMD_SECURE);
            OP_PROGRAM: step.data = cb(CMD_PROGRAM);
            OP_ABORT_RST: step.data = cb(CMD_RESET);
            OP_BYP_ENTER: step.data = cb(CMD_BYPASS);
            OP_BUF_PROG: begin
              step.addr = sect(addr_reg);
              step.data = cb(CMD_BUF_LOAD);
            end
            default: step.data = cb(CMD_ERASE_SETUP);
          endcase
        end else begin
          case (op_reg)
            OP_AUTOSEL: begin
              // offset read in the chosen sector
              step.wr = 1'b0;
              step.addr = sect(addr_reg) | {{(ADDR_W-8){1'b0}}, data_reg[7:0]};
            end
            OP_SEC_EXIT: step.data = cb(CMD_EXIT2);
            OP_PROGRAM: begin
              step.addr = addr_reg;
              step.data = data_reg;
            end
            OP_CHIP_ERASE: begin
              step.addr = ulk(UNLOCK_ADDR1);
              step.data = cb(CMD_CHIP_ERASE);
            end
            OP_SECT_ERASE: begin
              step.addr = sect(addr_reg);
              step.data = cb(CMD_SECTOR_ERASE);
            end
            OP_BUF_PROG: begin
              if (idx_reg == 5'd3) begin
                step.addr = sect(addr_reg);
                step.data = {12'h000, wc_reg};
              end else if (idx_reg == last_reg) begin
                step.addr = sect(addr_reg);
                step.data = cb(CMD_BUF_COMMIT);
              end else begin
                // consecutive words from the start address, page not checked
                step.addr = addr_reg + ADDR_W'(idx_reg - 5'd4);
                step.data = buf_data_i[4'(idx_reg - 5'd4)];
              end
            end
            default: step.data = '0;
          endcase
        end
      end
    endcase
  end

  // sequencer, one bus cycle at a time
  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    wc_next = wc_reg;
    idx_next = idx_reg;
    last_next = last_reg;
    rd_next = rd_reg;
    id1_next = id1_reg;
    id2_next = id2_reg;
    byp_next = byp_reg;
    susp_next = susp_reg;
    erasing_next = erasing_reg;
    done_next = 1'b0;
    bc_start = 1'b0;
    case (st_reg)
      HS_IDLE: begin
        if (cmd_valid_i) begin
          st_next = HS_ISSUE;
          op_next = cmd_op_i;
          addr_next = cmd_addr_i;
          data_next = cmd_data_i;
          wc_next = cmd_count_i;
          idx_next = '0;
          last_next = seq_last(cmd_op_i, cmd_count_i);
        end
      end
      HS_ISSUE: begin
        bc_start = 1'b1;
        st_next = HS_WAIT;
      end
      HS_WAIT: begin
        if (bc_done) begin
          // chained id reads go to the id words, rdata keeps offset 01
          if (!step.wr && !(op_reg == OP_AUTOSEL && data_reg[7:0] >= AS_PART1)) begin
            rd_next = bc_rdata;
          end
          if (op_reg == OP_AUTOSEL && idx_reg == 5'd3 && data_reg[7:0] == AS_PART0) begin
            data_next = cb(AS_PART1);
          end else if (op_reg == OP_AUTOSEL && data_reg[7:0] == AS_PART1) begin
            id1_next = bc_rdata;
            data_next = cb(AS_PART2);
          end else if (op_reg == OP_AUTOSEL && data_reg[7:0] == AS_PART2) begin
            id2_next = bc_rdata;
            data_next = cb(AS_MAKER);
          end
          if (op_reg == OP_AUTOSEL && (data_next != data_reg) && data_reg[7:0] != AS_PART2) begin
            st_next = HS_ISSUE;
          end else if (idx_reg == last_reg) begin
            st_next = HS_IDLE;
            done_next = 1'b1;
            // mode bookkeeping after each command
            case (op_reg)
              OP_BYP_ENTER: byp_next = 1'b1;
              OP_BYP_EXIT: byp_next = 1'b0;
              OP_RESET, OP_ABORT_RST: erasing_next = erasing_reg;
              OP_SECT_ERASE: erasing_next = 1'b1;
              OP_SUSPEND: susp_next = erasing_reg;
              OP_RESUME: susp_next = 1'b0;
              default: byp_next = byp_reg;
            endcase
          end else begin
            idx_next = idx_reg + 5'd1;
            st_next = HS_ISSUE;
          end
        end
      end
      default: st_next = HS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= HS_IDLE;
      op_reg <= OP_READ;
      addr_reg <= '0;
      data_reg <= '0;
      wc_reg <= '0;
      idx_reg <= '0;
      last_reg <= '0;
      rd_reg <= '0;
      id1_reg <= '0;
      id2_reg <= '0;
      byp_reg <= 1'b0;
      susp_reg <= 1'b0;
      erasing_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      wc_reg <= wc_next;
      idx_reg <= idx_next;
      last_reg <= last_next;
      rd_reg <= rd_next;
      id1_reg <= id1_next;
      id2_reg <= id2_next;
      byp_reg <= byp_next;
      susp_reg <= susp_next;
      erasing_reg <= erasing_next;
      done_reg <= done_next;
    end
  end

  fcd_bus_cycle u_cycle (
    .sys_clk_i  (sys_clk_i),
    .rst_b_i    (rst_b_i),
    .start_i    (bc_start),
    .is_write_i (step.wr),
    .addr_i     (step.addr),
    .wdata_i    (step.data),
    .dq_i       (flash_dq_i),
    .busy_o     (bc_busy),
    .done_o     (bc_done),
    .rdata_o    (bc_rdata),
    .addr_o     (flash_addr_o),
    .dq_o       (flash_dq_o),
    .dq_oe_o    (flash_dq_oe_o),
    .ce_b_o     (flash_ce_b_o),
    .we_b_o     (flash_we_b_o),
    .oe_b_o     (flash_oe_b_o)
  );

  // ready when idle and cycle engine quiet
  assign cmd_ready_o = (st_reg == HS_IDLE) && !bc_busy;
  assign done_o = done_reg;
  assign rdata_o = rd_reg;
  assign id_word1_o = id1_reg;
  assign id_word2_o = id2_reg;
  assign bypass_o = byp_reg;
  assign suspended_o = susp_reg;
endmodule

// ==== tb/fcd_host_sva.sv ====
`timescale 1ns/1ps
// flash bus protocol checks
module fcd_host_sva
  import fcd_pkg::*;
(
  input wire logic              sys_clk_i,
  input wire logic              rst_b_i,
  input wire logic              cmd_valid_i,
  input wire fcd_op_t           cmd_op_i,
  input wire logic              cmd_ready_o,
  input wire logic              done_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic              flash_dq_oe_o,
  input wire logic              flash_ce_b_o,
  input wire logic              flash_we_b_o,
  input wire logic              flash_oe_b_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // unlock writes at falling strobe
  sequence s_unlock1;
    $fell(flash_we_b_o) && flash_addr_o[10:0] == UNLOCK_ADDR1
      && flash_dq_o[7:0] == CMD_UNLOCK1;
  endsequence
  sequence s_unlock2;
    $fell(flash_we_b_o) && flash_addr_o[10:0] == UNLOCK_ADDR2
      && flash_dq_o[7:0] == CMD_UNLOCK2;
  endsequence
  sequence s_take_byp;
    cmd_valid_i && cmd_ready_o && cmd_op_i == OP_BYP_ENTER;
  endsequence

  property p_unlock;
    s_take_byp |-> ##[1:6] s_unlock1 ##[1:6] s_unlock2;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("no unlock pair");

  property p_we_pulse;
    $fell(flash_we_b_o) |-> !flash_we_b_o [*2] ##1 flash_we_b_o;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("bad we width");

  property p_we_qual;
    !flash_we_b_o |-> !flash_ce_b_o && flash_oe_b_o && flash_dq_oe_o;
  endproperty
  a_we_qual: assert property (p_we_qual)
    else $error("we without ce or data");

  property p_hold;
    !flash_we_b_o && $past(!flash_we_b_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus moved under we");

  property p_no_fight;
    !flash_oe_b_o |-> !flash_dq_oe_o && !flash_ce_b_o;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("drive during read");

  property p_rd_len;
    $fell(flash_oe_b_o) |-> !flash_oe_b_o [*4] ##1 flash_oe_b_o;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("bad oe width");

  property p_done_pulse;
    done_o |=> !done_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("long done");

  property p_take;
    cmd_valid_i && cmd_ready_o |=> !cmd_ready_o;
  endproperty
  a_take: assert property (p_take)
    else $error("ready after take");

  property p_idle_quiet;
    cmd_ready_o |-> flash_we_b_o && flash_oe_b_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("strobe while idle");
endmodule

bind fcd_host fcd_host_sva u_sva (.sys_clk_i, .rst_b_i, .cmd_valid_i, .cmd_op_i,
  .cmd_ready_o, .done_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o,
  .flash_ce_b_o, .flash_we_b_o, .flash_oe_b_o);

// ==== tb/fcd_flash_model.sv ====
`timescale 1ns/1ps
// flash array and decoder
module fcd_flash_model
  import fcd_pkg::*;
#(
  parameter logic [15:0] MAKER_ID  = 16'h00a5, // arbitrary value
  parameter logic [15:0] PART_ID0  = 16'h1111, // arbitrary value
  parameter logic [15:0] PART_ID1  = 16'h2222, // arbitrary value
  parameter logic [15:0] PART_ID2  = 16'h3333, // arbitrary value
  parameter logic [15:0] LOCK_STAT = 16'h0080,
  parameter logic [6:0]  PROT_SEC  = 7'h02,
  parameter int          ERS_NS    = 1000,
  parameter int          RD_NS     = 20
)(
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] dq_i,
  input  wire logic              ce_b_i,
  input  wire logic              we_b_i,
  input  wire logic              oe_b_i,
  output wire logic [DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] pend [int];
  logic [ADDR_W-1:0] la, sa;
  logic [DATA_W-1:0] rv, last = '0;
  int      st = 0, bn, bi;
  bit      asel, sec, byp, pgm, susp, cfi, abrt;
  realtime ers_end = 0, chip_end = 0;
  wire     wr_b = ce_b_i | we_b_i;

  // address on later falling strobe
  always @(negedge wr_b) la = addr_i;
  // data and decode on the first rising strobe
  always @(posedge wr_b) begin : dec
    logic [7:0]  c;
    logic [10:0] lo;
    int          q[$];
    c = dq_i[7:0];
    lo = la[10:0];
    if ($realtime < chip_end) disable dec;
    if (pgm) begin
      mem[la] = dq_i;
      pgm = 0;
    end else if (st == 6) begin
      bn = dq_i;
      bi = 0;
      pend.delete();
      st = 7;
    end else if (st == 7) begin
      if (la[ADDR_W-1:4] != sa[ADDR_W-1:4] && bi > 0) abrt = 1;
      if (bi == 0) sa = la;
      pend[la] = dq_i;
      bi++;
      if (bi > bn) st = 8;
    end else if (st == 8) begin
      if (c == 8'h29 && !abrt) foreach (pend[k]) mem[k] = pend[k];
      st = 0;
    end else if (st == 1) st = (lo == 11'h2aa && c == 8'h55) ? 2 : 0;
    else if (st == 2) begin
      st = 0;
      if (c == 8'h25) st = 6;
      else if (lo == 11'h555) case (c)
        8'h90: asel = 1;
        8'h88: sec = 1;
        8'ha0: pgm = 1;
        8'h20: byp = 1;
        8'hf0: abrt = 0;
        8'h80: st = 3;
        default: ;
      endcase
    end else if (st == 3) st = (lo == 11'h555 && c == 8'haa) ? 4 : 0;
    else if (st == 4) st = (lo == 11'h2aa && c == 8'h55) ? 5 : 0;
    else if (st == 5) begin
      st = 0;
      if (lo == 11'h555 && c == 8'h10) begin
        mem.delete();
        chip_end = $realtime + ERS_NS;
      end else if (c == 8'h30) begin
        foreach (mem[k]) if (k[21:15] == la[21:15]) q.push_back(k);
        foreach (q[i]) mem.delete(q[i]);
        ers_end = $realtime + ERS_NS;
      end
    end
    else if (lo == 11'h555 && c == 8'haa) st = 1;
    else if (c == 8'hf0) {asel, cfi} = 2'b00;
    else if (asel && c == 8'h00) {asel, sec, byp} = 3'b000;
    else if (byp && c == 8'ha0) pgm = 1;
    else if (byp && c == 8'h90) asel = 1;
    else if (c == 8'hb0 && $realtime < ers_end) susp = 1;
    else if (c == 8'h30 && susp) begin
      susp = 0;
      ers_end = $realtime + ERS_NS;
    end
    else if (c == 8'h98 && lo == 11'h055 && (asel || !byp)) cfi = 1;
  end

  // released bus shows inverse of last word
  always @(addr_i or ce_b_i or oe_b_i or asel) begin
    if (!asel) rv = mem.exists(addr_i) ? mem[addr_i] : 16'hffff;
    else case (addr_i[7:0])
      8'h00: rv = MAKER_ID;
      8'h01: rv = PART_ID0;
      8'h0e: rv = PART_ID1;
      8'h0f: rv = PART_ID2;
      8'h02: rv = {15'h0, addr_i[21:15] == PROT_SEC};
      8'h03: rv = LOCK_STAT;
      default: rv = 16'h0000;
    endcase
  end
  always @(posedge oe_b_i) last = rv;
  assign #(RD_NS) dq_o = (!ce_b_i && !oe_b_i) ? rv : ~last;
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// host against flash model
module tb_top
  import fcd_pkg::*;
;
  logic              sys_clk_i = 0, rst_b_i = 0, cmd_valid_i = 0;
  fcd_op_t           cmd_op_i = OP_READ;
  logic [ADDR_W-1:0] cmd_addr_i = '0, flash_addr_o;
  logic [DATA_W-1:0] cmd_data_i = '0, rdata_o, id_word1_o, id_word2_o;
  logic [3:0]        cmd_count_i = '0;
  logic [DATA_W-1:0] buf_data_i [BUF_WORDS] = '{default: '0};
  logic              cmd_ready_o, done_o, bypass_o, suspended_o, flash_dq_oe_o;
  logic              flash_ce_b_o, flash_we_b_o, flash_oe_b_o;
  logic [DATA_W-1:0] flash_dq_o, mdl_dq;
  wire  [DATA_W-1:0] dq_bus = flash_dq_oe_o ? flash_dq_o : mdl_dq;
  int                errors = 0, tests_run = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  fcd_host dut (.sys_clk_i, .rst_b_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i,
    .cmd_data_i, .cmd_count_i, .buf_data_i, .cmd_ready_o, .done_o, .rdata_o,
    .id_word1_o, .id_word2_o, .bypass_o, .suspended_o, .flash_addr_o,
    .flash_dq_o, .flash_dq_oe_o, .flash_dq_i(dq_bus), .flash_ce_b_o,
    .flash_we_b_o, .flash_oe_b_o);
  fcd_flash_model mdl (.addr_i(flash_addr_o), .dq_i(dq_bus), .ce_b_i(flash_ce_b_o),
    .we_b_i(flash_we_b_o), .oe_b_i(flash_oe_b_o), .dq_o(mdl_dq));

  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one command; ready and done read at negedge to avoid edge races
  task automatic cmd(input fcd_op_t op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [3:0] n);
    int k = 0;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    cmd_count_i <= n;
    @(negedge sys_clk_i);
    while (cmd_ready_o !== 1'b1 && k < 50) begin
      @(negedge sys_clk_i);
      k++;
    end
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    while (done_o !== 1'b1 && k < 450) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k >= 450) begin
      errors++;
      $display("MISMATCH %0t no completion", $time);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    cmd(OP_READ, a, '0, '0);
    chk(rdata_o, e);
  endtask

  // read, program, autoselect
  task automatic t_basic;
    rd(22'h012345, 16'hffff);
    cmd(OP_PROGRAM, 22'h3f0123, 16'h5a3c, '0);
    rd(22'h3f0123, 16'h5a3c);
    cmd(OP_AUTOSEL, 22'h010000, 16'h0000, '0);
    chk(rdata_o, mdl.MAKER_ID);
    cmd(OP_AUTOSEL, 22'h010000, 16'h0001, '0);
    chk(rdata_o, mdl.PART_ID0);
    chk(id_word1_o, mdl.PART_ID1);
    chk(id_word2_o, mdl.PART_ID2);
    cmd(OP_AUTOSEL, 22'h010000, 16'h0002, '0);
    chk(rdata_o, 16'h0001);
    cmd(OP_AUTOSEL, 22'h018000, 16'h0002, '0);
    chk(rdata_o, 16'h0000);
    cmd(OP_AUTOSEL, 22'h000000, 16'h0003, '0);
    chk(rdata_o, mdl.LOCK_STAT);
    cmd(OP_RESET, '0, '0, '0);
    rd(22'h3f0123, 16'h5a3c);
  endtask
  // buffer of n+1 words
  task automatic t_buffer(input logic [ADDR_W-1:0] a, input logic [3:0] n);
    for (int i = 0; i <= n; i++) buf_data_i[i] <= a[15:0] ^ 16'(i * 9);
    cmd(OP_BUF_PROG, a, '0, n);
    for (int i = 0; i <= n; i++) rd(a + 22'(i), a[15:0] ^ 16'(i * 9));
    cmd(OP_ABORT_RST, '0, '0, '0);
    chk(16'(mdl.abrt), 16'h0000);
  endtask
  // bypass
  task automatic t_bypass;
    cmd(OP_BYP_ENTER, '0, '0, '0);
    chk(16'(bypass_o & mdl.byp), 16'h0001);
    cmd(OP_BYP_PROG, 22'h2a0007, 16'hc3a5, '0);
    cmd(OP_BYP_EXIT, '0, '0, '0);
    chk(16'(bypass_o | mdl.byp), 16'h0000);
    rd(22'h2a0007, 16'hc3a5);
  endtask
  // erase, suspend, resume
  task automatic t_erase;
    cmd(OP_PROGRAM, 22'h028010, 16'h7777, '0);
    cmd(OP_SECT_ERASE, 22'h02fffe, '0, '0);
    cmd(OP_SUSPEND, '0, '0, '0);
    chk(16'(suspended_o & mdl.susp), 16'h0001);
    rd(22'h028010, 16'hffff);
    rd(22'h3f0123, 16'h5a3c);
    cmd(OP_RESUME, '0, '0, '0);
    chk(16'(suspended_o | mdl.susp), 16'h0000);
    repeat (50) @(posedge sys_clk_i);
    cmd(OP_SUSPEND, '0, '0, '0);
    chk(16'(mdl.susp), 16'h0000);
    cmd(OP_RESUME, '0, '0, '0);
  endtask
  // secured, query, chip erase
  task automatic t_misc;
    cmd(OP_SEC_ENTER, '0, '0, '0);
    chk(16'(mdl.sec), 16'h0001);
    cmd(OP_SEC_EXIT, '0, '0, '0);
    chk(16'(mdl.sec | mdl.asel), 16'h0000);
    cmd(OP_CFI, '0, '0, '0);
    chk(16'(mdl.cfi), 16'h0001);
    cmd(OP_RESET, '0, '0, '0);
    cmd(OP_CHIP_ERASE, '0, '0, '0);
    cmd(OP_PROGRAM, 22'h000100, 16'h0bad, '0);
    repeat (60) @(posedge sys_clk_i);
    rd(22'h000100, 16'hffff);
    rd(22'h3f0123, 16'hffff);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_basic();
    t_buffer(22'h02004c, 4'h3);
    t_buffer(22'h030020, 4'hf);
    t_bypass();
    t_erase();
    t_misc();
    give_verdict();
  end
  // watchdog, run needs about a thousand cycles
  initial begin
    #(25 * 20000);
    errors++;
    give_verdict();
  end
endmodule
